// ### core/sdram_burst_core.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_burst_core
    import sdram_burst_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // sdram command pins, synchronous to hclk
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [BANK_W-1:0] ba,
    input wire logic [ROW_W-1:0] addr,
    input wire logic dqm,
    // data pins as three signals
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    // bank auto precharge request, one pulse per auto precharge (a precharge command gives none)
    output logic [3:0] precharge_pulse
);
    // ========================================
    // state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } burst_st_t;

    cmd_bus_t cb;
    assign cb = '{cmd: {cs_n, ras_n, cas_n, we_n}, bank: ba, addr: addr,
                  mask: dqm, din: dq_in};

    logic [31:0] mode_reg, mode_next;
    logic [31:0] count_reg;
    burst_st_t st_reg, st_next;
    logic [COL_W-1:0] col_reg, col_next;
    logic [BANK_W-1:0] bank_reg;
    logic [LINE_W+4:0] left_reg, left_next;
    logic ap_reg;
    logic page_reg;
    logic [2:0] mask_pipe_reg;
    logic [2:0] rdv_pipe_reg;
    logic [DATA_W-1:0] rd_pipe_reg [3];
    logic [DATA_W-1:0] dq_out_reg;
    logic dq_oe_reg;
    logic [3:0] pre_reg;

    // ========================================
    // mode fields
    wire lat3 = mode_reg[LAT_BIT];
    wire [2:0] bl = mode_reg[BL_LSB +: 3];
    wire wbm = mode_reg[WBM_BIT];

    // ========================================
    // command decode
    wire is_rd = cb.cmd == CMD_READ;
    wire is_wr = cb.cmd == CMD_WRITE;
    wire is_pre = cb.cmd == CMD_PRE;
    wire is_stop = cb.cmd == CMD_STOP;
    wire ap_flag = cb.addr[10];

    function automatic logic [LINE_W+4:0] burst_len(input logic [2:0] code);
        case (code)
            BL_1: burst_len = 10'd1;
            BL_2: burst_len = 10'd2;
            BL_4: burst_len = 10'd4;
            BL_8: burst_len = 10'd8;
            default: burst_len = 10'd0;      // zero marks a page burst
        endcase
    endfunction

    // write burst mode gives single column writes
    wire [2:0] wr_bl = wbm ? BL_1 : bl;
    wire [COL_W-1:0] col_step;
    wire [COL_W-1:0] cmd_col = cb.addr[COL_W-1:0];
    wire cmd_edge = is_rd || is_wr;
    wire [2:0] cmd_bl = is_rd ? bl : wr_bl;
    wire [LINE_W+4:0] cmd_len = burst_len(cmd_bl);

    // on a command edge the step starts from the command column, so the
    // second word of a burst never repeats the first one
    sdram_col_step u_step (
        .bl(cmd_edge ? cmd_bl : (st_reg == ST_WRITE ? wr_bl : bl)),
        .col(cmd_edge ? cmd_col : col_reg),
        .col_next(col_step)
    );

    // ========================================
    // burst sequencer
    wire burst_last = !page_reg && left_reg == 10'd1;
    wire active = st_reg != ST_IDLE;
    always_comb begin
        st_next = st_reg;
        col_next = col_reg;
        left_next = left_reg;
        if (cmd_edge) begin
            st_next = is_rd ? ST_READ : ST_WRITE;
            col_next = col_step;
            left_next = cmd_len - 10'd1;
            if (cmd_len == 10'd1) begin
                st_next = ST_IDLE;
            end
            if (cmd_len == 10'd0) begin
                left_next = 10'd0;
            end
        end else if (is_stop || is_pre) begin
            st_next = ST_IDLE;
        end else if (active) begin
            col_next = col_step;
            if (!page_reg) begin
                left_next = left_reg - 10'd1;
            end
            if (burst_last) begin
                st_next = ST_IDLE;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= ST_IDLE;
            col_reg <= '0;
            left_reg <= '0;
            bank_reg <= '0;
            ap_reg <= 1'b0;
            page_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            col_reg <= col_next;
            left_reg <= left_next;
            if (is_rd || is_wr) begin
                bank_reg <= cb.bank;
                ap_reg <= ap_flag;
                page_reg <= (is_rd ? bl : wr_bl) == BL_PAGE;
            end
        end
    end

    // ========================================
    // write path: word on the command edge, then each edge
    array_wr_t wr;
    wire wr_cont = st_reg == ST_WRITE && !is_rd && !is_stop && !is_pre;
    assign wr = '{en: (is_wr || wr_cont) && !cb.mask,
                  bank: is_wr ? cb.bank : bank_reg,
                  col: is_wr ? cmd_col : col_reg,
                  data: cb.din};

    // read address: command column on the read edge, else burst column
    wire rd_now = is_rd || (st_reg == ST_READ && !is_stop && !is_pre
                            && !is_wr);
    wire [DATA_W-1:0] arr_q;
    sdram_bank_array #(.BANKS(4)) u_array (
        .hclk(hclk),
        .wr(wr),
        .rd_bank(is_rd ? cb.bank : bank_reg),
        .rd_col(is_rd ? cmd_col : col_reg),
        .rd_data(arr_q)
    );

    // ========================================
    // auto precharge once the burst closes itself
    wire ap_done = active && ap_reg && !page_reg && burst_last
                   && !is_rd && !is_wr;
    wire ap_single = cmd_edge && ap_flag && cmd_len == 10'd1;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_reg <= 4'h0;
        end else begin
            pre_reg <= 4'h0;
            if (ap_done) begin
                pre_reg[bank_reg] <= 1'b1;
            end
            if (ap_single) begin
                pre_reg[cb.bank] <= 1'b1;
            end
        end
    end
    assign precharge_pulse = pre_reg;

    // ========================================
    // read latency pipe (two or three clocks) and output mask (two clock latency)
    wire [1:0] tap = lat3 ? 2'd2 : 2'd1;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdv_pipe_reg <= 3'h0;
            mask_pipe_reg <= 3'h0;
        end else begin
            // a registered write drops every read word still in flight
            rdv_pipe_reg <= is_wr ? 3'h0 : {rdv_pipe_reg[1:0], rd_now};
            mask_pipe_reg <= {mask_pipe_reg[1:0], cb.mask};
        end
    end

    always_ff @(posedge hclk) begin
        rd_pipe_reg[0] <= arr_q;
        rd_pipe_reg[1] <= rd_pipe_reg[0];
        rd_pipe_reg[2] <= rd_pipe_reg[1];
    end

    // a write kills pending read data outright
    wire rd_due = rdv_pipe_reg[tap - 2'd1] && !is_wr;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dq_oe_reg <= 1'b0;
            dq_out_reg <= '0;
        end else begin
            dq_oe_reg <= rd_due && !mask_pipe_reg[0];
            dq_out_reg <= rd_pipe_reg[tap - 2'd1];
        end
    end
    assign dq_oe = dq_oe_reg;
    assign dq_out = dq_out_reg;

    // ========================================
    // ahb-lite slave: zero wait, always okay
    logic ph_wr_reg;
    logic [7:0] ph_addr_reg;
    wire take = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_reg <= 1'b0;
            ph_addr_reg <= 8'h00;
        end else begin
            ph_wr_reg <= take && hwrite;
            ph_addr_reg <= take ? haddr : ph_addr_reg;
        end
    end
    always_comb begin
        mode_next = mode_reg;
        if (ph_wr_reg && ph_addr_reg == MODE_OFF) begin
            mode_next = hwdata & 32'h0000_001f;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= MODE_RST;
            count_reg <= 32'h0000_0000;
        end else begin
            mode_reg <= mode_next;
            count_reg <= count_reg + {31'h0, wr.en};
        end
    end
    assign hrdata = (ph_addr_reg == MODE_OFF) ? mode_reg :
                    (ph_addr_reg == STAT_OFF) ?
                        {27'h0, page_reg, ap_reg, dq_oe_reg, st_reg} :
                    (ph_addr_reg == COUNT_OFF) ? count_reg : 32'h0;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ========================================
    // checks
    a_read_latency: assert property (@(posedge hclk) disable iff (!hresetn)
        is_rd && !lat3 && !dqm ##1 !is_wr |=> dq_oe)
        else $error("read data missing at latency two");
    a_read_latency_three: assert property (@(posedge hclk)
        disable iff (!hresetn) is_rd && lat3 && !dqm ##1 !is_wr && !dqm
        ##1 !is_wr |=> dq_oe)
        else $error("read data missing at latency three");
    a_write_release: assert property (@(posedge hclk) disable iff (!hresetn)
        is_wr |=> !dq_oe [*2])
        else $error("pins driven after write");
    a_read_ends_write: assert property (@(posedge hclk)
        disable iff (!hresetn) is_rd |-> !wr.en)
        else $error("write performed on read edge");
    a_stop_ignores: assert property (@(posedge hclk) disable iff (!hresetn)
        is_stop |-> !wr.en)
        else $error("data taken with stop");
    a_idle_release: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg == ST_IDLE && !is_rd ##1 !is_rd [*2] |=> !dq_oe)
        else $error("pins not released after burst");
    a_write_capture: assert property (@(posedge hclk) disable iff (!hresetn)
        is_wr && !dqm |-> wr.en && wr.col == cmd_col)
        else $error("first write word not captured");
    a_single_write: assert property (@(posedge hclk) disable iff (!hresetn)
        is_wr && wbm |=> st_reg == ST_IDLE)
        else $error("burst write in single write mode");
    a_write_done: assert property (@(posedge hclk) disable iff (!hresetn)
        st_reg == ST_IDLE && !is_wr |-> !wr.en)
        else $error("write after burst end");
endmodule
`default_nettype wire

// ### core/sdram_burst_pkg.sv
package sdram_burst_pkg;
    // ========================================
    // geometry and timing
    localparam int COL_W = 9;
    localparam int ROW_W = 12;
    localparam int BANK_W = 2;
    localparam int DATA_W = 16;
    localparam int LINE_W = 5;
    localparam int MASK_OUT_LAT = 2;
    localparam int WR_REC_NS = 15;
    localparam int CLK_NS = 10;
    localparam int WR_REC_CYC = (WR_REC_NS + CLK_NS - 1) / CLK_NS;

    // ========================================
    // register map (word aligned)
    localparam logic [7:0] MODE_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [7:0] COUNT_OFF = 8'h08;
    localparam int LAT_BIT = 0;
    localparam int BL_LSB = 1;
    localparam int WBM_BIT = 4;
    localparam logic [31:0] MODE_RST = 32'h0000_0007;

    // burst_length_setting codes
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;

    // ========================================
    // command encoding {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        CMD_NOP   = 4'b0111,
        CMD_READ  = 4'b0101,
        CMD_WRITE = 4'b0100,
        CMD_PRE   = 4'b0010,
        CMD_STOP  = 4'b0110
    } sdram_cmd_t;

    // command bundle as sampled
    typedef struct packed {
        logic [3:0] cmd;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] addr;
        logic mask;
        logic [DATA_W-1:0] din;
    } cmd_bus_t;

    // one write into the array
    typedef struct packed {
        logic en;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
        logic [DATA_W-1:0] data;
    } array_wr_t;
endpackage

// ### core/sdram_col_step.sv
`timescale 1ns/1ps
`default_nettype none
// next column inside the burst block, wrapping at block or page edge
module sdram_col_step
    import sdram_burst_pkg::*;
(
    // burst setting and current column
    input wire logic [2:0] bl,
    input wire logic [COL_W-1:0] col,
    // next column
    output logic [COL_W-1:0] col_next
);
    // ========================================
    // mask of the low bits that wrap inside the block
    wire [COL_W-1:0] wrap_mask = (bl == BL_2) ? 9'h001 :
                                 (bl == BL_4) ? 9'h003 :
                                 (bl == BL_8) ? 9'h007 : 9'h1ff;
    wire [COL_W-1:0] inc = col + 9'h001;
    // page bursts wrap to column 0 by natural overflow
    assign col_next = (col & ~wrap_mask) | (inc & wrap_mask);
endmodule
`default_nettype wire

// ### core/sdram_bank_array.sv
`timescale 1ns/1ps
`default_nettype none
// storage of the open rows; row address is not modelled
module sdram_bank_array
    import sdram_burst_pkg::*;
#(
    parameter int BANKS = 4
)
(
    // clock
    input wire logic hclk,
    // write port
    input wire array_wr_t wr,
    // read port
    input wire logic [BANK_W-1:0] rd_bank,
    input wire logic [COL_W-1:0] rd_col,
    output logic [DATA_W-1:0] rd_data
);
    // ========================================
    logic [DATA_W-1:0] mem [BANKS*(1<<COL_W)];
    wire [BANK_W+COL_W-1:0] wa = {wr.bank, wr.col};
    wire [BANK_W+COL_W-1:0] ra = {rd_bank, rd_col};

    // no reset on storage, contents are don't care at power up
    always_ff @(posedge hclk) begin
        if (wr.en) begin
            mem[wa] <= wr.data;
        end
    end
    assign rd_data = mem[ra];
endmodule
`default_nettype wire

// ### tb/sdram_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller side: commands, mask and write data, changed after each edge
module sdram_ctrl_model
    import sdram_burst_pkg::*;
(
    // clock
    input wire logic hclk,
    // command pins
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [BANK_W-1:0] ba,
    output logic [ROW_W-1:0] addr,
    // mask and write data
    output logic dqm,
    output logic [DATA_W-1:0] dq_in
);
    // ========================================
    // idle bus at time zero
    initial begin
        {cs_n, ras_n, cas_n, we_n} = CMD_NOP;
        ba = '0;
        addr = '0;
        dqm = 1'b0;
        dq_in = 16'h0f0f;
    end

    // ========================================
    // one command per edge; spacing is left to the caller's sequence
    task automatic issue(input sdram_cmd_t c, input logic [BANK_W-1:0] b,
        input logic [ROW_W-1:0] a, input logic m, input logic drv,
        input logic [DATA_W-1:0] d);
        @(posedge hclk);
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        dqm <= m;
        // a released data line flips so stale data never matches
        dq_in <= drv ? d : ~dq_in;
    endtask
endmodule
`default_nettype wire

// ### tb/sdram_read_write_bursts_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_read_write_bursts_tb
    import sdram_burst_pkg::*;
;
    // ========================================
    // signals
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dq_oe, dqm;
    logic cs_n, ras_n, cas_n, we_n;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, last_cnt, rdv;
    logic [BANK_W-1:0] ba;
    logic [ROW_W-1:0] addr;
    logic [DATA_W-1:0] dq_in, dq_out;
    logic [3:0] precharge_pulse;
    int failures = 0;
    int n_compared = 0;
    int pc1 = 0;

    // clock at 100 MHz
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // auto precharge pulses seen on bank one
    always @(posedge hclk) pc1 <= pc1 + int'(precharge_pulse[1]);

    sdram_burst_core u_sdram_burst_core (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .precharge_pulse(precharge_pulse)
    );
    sdram_ctrl_model u_sdram_ctrl_model (
        .hclk(hclk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in)
    );

    // ========================================
    // checking and verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ========================================
    // ahb-lite single word transfer; waits on hready, giving up after 100 cycles per phase
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        int k;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'b010;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 100);
        htrans <= 2'b00;
        hwdata <= wd;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 100);
        rd = hrdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0, rdv);
        chk(rdv, e);
    endtask

    task automatic mode(input logic [31:0] v);
        ahb(1'b1, MODE_OFF, v, rdv);
        rchk(MODE_OFF, v);
    endtask

    // written-word counter compared as a difference from the last look
    task automatic cnt_chk(input logic [31:0] e);
        ahb(1'b0, COUNT_OFF, 32'h0, rdv);
        chk(rdv - last_cnt, e);
        last_cnt = rdv;
    endtask

    // ========================================
    // sdram cycles: one command per tick, outputs looked at mid-cycle
    function automatic logic [15:0] pat(input logic [1:0] b,
        input logic [8:0] c);
        return {3'h5, b, 2'h0, c};
    endfunction

    task automatic t(input sdram_cmd_t c, input logic [1:0] b,
        input logic [11:0] a, input logic m, input logic drv,
        input logic [15:0] d);
        u_sdram_ctrl_model.issue(c, b, a, m, drv, d);
        @(negedge hclk);
    endtask

    task automatic nop();
        t(CMD_NOP, 2'd0, 12'h0, 1'b0, 1'b0, 16'h0);
    endtask

    task automatic ckd(input logic oe, input logic [15:0] d);
        chk({15'h0, dq_oe, oe ? dq_out : 16'h0}, {15'h0, oe, d});
    endtask

    task automatic rdchk(input logic [1:0] b, input logic [11:0] a,
        input int w, input int n);
        int i;
        t(CMD_READ, b, a, 1'b0, 1'b0, 16'h0);
        // w is the read latency: the first word stands after edge w - 1
        repeat (w - 1) nop();
        for (i = 0; i < n; i++) begin
            nop();
            ckd(1'b1, pat(b, a[8:0] + 9'(i)));
        end
        nop();
        ckd(1'b0, 16'h0);
    endtask

    task automatic wrb(input logic [1:0] b, input logic [8:0] c,
        input int n, input int g);
        int i;
        t(CMD_WRITE, b, {3'h0, c}, 1'b0, 1'b1, pat(b, c));
        for (i = 1; i < n; i++) begin
            t(CMD_NOP, 2'd0, 12'h0, 1'b0, 1'b1, pat(b, c + 9'(i)));
        end
        repeat (g) t(CMD_NOP, 2'd0, 12'h0, 1'b0, 1'b1, 16'hdead);
    endtask

    // two wanted words, ending command one cycle before the last (cl 2)
    task automatic trunc(input sdram_cmd_t c, input logic [1:0] b,
        input logic [8:0] col);
        t(CMD_READ, b, {3'h0, col}, 1'b0, 1'b0, 16'h0);
        nop();
        t(c, b, 12'h0, 1'b0, 1'b0, 16'h0);
        ckd(1'b1, pat(b, col));
        nop();
        ckd(1'b1, pat(b, col + 9'd1));
        nop();
        ckd(1'b0, 16'h0);
        repeat (3) nop();
    endtask

    // ========================================
    // main sequence
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hsize, hwdata} = '0;
        last_cnt = 32'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(MODE_OFF, MODE_RST);
        ahb(1'b1, 8'h40, 32'hffff_ffff, rdv);
        rchk(8'h40, 32'h0);
        cnt_chk(32'd0);
        mode(32'h0000_0004);
        wrb(2'd1, 9'd8, 4, 2);
        wrb(2'd2, 9'd0, 4, 0);
        cnt_chk(32'd8);
        rdchk(2'd1, 12'd8, 2, 4);
        t(CMD_READ, 2'd1, 12'd8, 1'b0, 1'b0, 16'h0);
        rdchk(2'd2, 12'd0, 2, 4);
        chk(32'(pc1), 32'd0);
        // a new write takes the burst over at once
        t(CMD_WRITE, 2'd0, 12'd0, 1'b0, 1'b1, pat(2'd0, 9'd0));
        wrb(2'd0, 9'd4, 4, 0);
        cnt_chk(32'd5);
        rdchk(2'd0, 12'd4, 2, 4);
        // read and stop both cut a write short
        wrb(2'd3, 9'd0, 2, 0);
        rdchk(2'd1, 12'd8, 2, 4);
        cnt_chk(32'd2);
        wrb(2'd3, 9'd4, 2, 0);
        t(CMD_STOP, 2'd3, 12'h0, 1'b0, 1'b1, 16'hbeef);
        cnt_chk(32'd2);
        // precharge one recovery time after the last word, masked around it
        t(CMD_WRITE, 2'd3, 12'd8, 1'b0, 1'b1, pat(2'd3, 9'd8));
        t(CMD_NOP, 2'd0, 12'h0, 1'b0, 1'b1, pat(2'd3, 9'd9));
        repeat (WR_REC_CYC - 1) begin
            t(CMD_NOP, 2'd0, 12'h0, 1'b1, 1'b1, 16'hdead);
        end
        t(CMD_PRE, 2'd3, 12'h0, 1'b1, 1'b1, 16'hdead);
        cnt_chk(32'd2);
        mode(32'h0000_0014);
        wrb(2'd1, 9'd12, 4, 0);
        cnt_chk(32'd1);
        mode(32'h0000_0005);
        rdchk(2'd1, 12'h408, 3, 4);
        repeat (4) nop();
        chk(32'(pc1), 32'd1);
        // page bursts wrap from the last column to column zero
        mode(32'h0000_000e);
        wrb(2'd2, 9'd511, 2, 0);
        t(CMD_STOP, 2'd2, 12'h0, 1'b0, 1'b1, 16'hbeef);
        cnt_chk(32'd2);
        trunc(CMD_STOP, 2'd2, 9'd511);
        mode(32'h0000_0004);
        trunc(CMD_PRE, 2'd1, 9'd8);
        // mask raised two clocks ahead lets a write cut a read
        t(CMD_READ, 2'd1, 12'd8, 1'b0, 1'b0, 16'h0);
        t(CMD_NOP, 2'd0, 12'h0, 1'b1, 1'b0, 16'h0);
        t(CMD_NOP, 2'd0, 12'h0, 1'b1, 1'b0, 16'h0);
        ckd(1'b1, pat(2'd1, 9'd8));
        t(CMD_WRITE, 2'd0, 12'd8, 1'b0, 1'b1, pat(2'd0, 9'd8));
        ckd(1'b0, 16'h0);
        for (int i = 1; i < 4; i++) begin
            t(CMD_NOP, 2'd0, 12'h0, 1'b0, 1'b1, pat(2'd0, 9'(8 + i)));
            ckd(1'b0, 16'h0);
        end
        cnt_chk(32'd4);
        rdchk(2'd0, 12'd8, 2, 4);
        results();
    end

    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge hclk);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end
endmodule
`default_nettype wire
